// ===== hdl/ucb_pkg.sv
// Purpose: shared constants and carrier types for the USB configuration bus router
// Assumes: one 10 MHz system clock
// Notes: request codes, record codes and error words live here
package ucb_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned STROBE_HIGH_NS = 100;
  localparam int unsigned STROBE_HIGH_CYC =
    ((STROBE_HIGH_NS * (CLK_HZ / 1000000)) + 999) / 1000;
  localparam int unsigned BUS_TIMEOUT_US = 100;
  localparam int unsigned BUS_TIMEOUT_CYC = BUS_TIMEOUT_US * (CLK_HZ / 1000000);
  localparam int unsigned LAMP_HOLD_MS = 50;
  localparam int unsigned LAMP_HOLD_CYC = LAMP_HOLD_MS * (CLK_HZ / 1000);

  // Widths
  localparam int unsigned NUM_FPGA = 4;
  localparam int unsigned SEL_W = 8;
  localparam int unsigned LEN_W = 16;

  // Control request codes
  localparam logic [7:0] REQ_SELECT_TARGET = 8'hB7;
  localparam logic [7:0] REQ_DESELECT_TARGET = 8'hBD;
  localparam logic [7:0] REQ_READ_LENGTH = 8'hBB;
  localparam logic [SEL_W-1:0] FIRST_TARGET = 8'h01;

  // Record codes on the write endpoint
  localparam logic [7:0] REC_LOAD_ADDR = 8'h00;
  localparam logic [7:0] REC_WRITE_DATA = 8'h01;
  localparam logic [2:0] REC_LEN = 3'h5;
  localparam logic [1:0] WORD_LAST = 2'h3;

  // Answers on bus faults
  localparam logic [31:0] ERR_TIMEOUT = 32'hDEADDEAD;
  localparam logic [31:0] ERR_DISABLED = 32'h12345678;

  // Reset values
  localparam logic [31:0] ADDR_RST = 32'h00000000;
  localparam logic [7:0] CFG_BYTE_RST = 8'h00;

  // Control request from the microcontroller
  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [SEL_W-1:0] arg;
    logic [LEN_W-1:0] value;
  } ucb_req_s;

  // User-side bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [31:0] addr;
    logic [31:0] data;
  } ucb_ubus_s;

  // Decode of a one-based target number to a one-hot select
  function automatic logic [NUM_FPGA-1:0] target_onehot(input logic [SEL_W-1:0] num);
    logic [NUM_FPGA-1:0] oh;
    oh = '0;
    for (int i = 0; i < NUM_FPGA; i++)
    begin
      if (num == SEL_W'(i + 1))
      begin
        oh[i] = 1'b1;
      end
    end
    return oh;
  endfunction : target_onehot

endpackage : ucb_pkg

// ===== hdl/ucb_cfg_port.sv
// Purpose: drives one byte and one strobe pulse per byte on the parallel config port
// Assumes: caller offers a byte only when rdy is high
// Notes: byte is set up one cycle before the strobe rises and held through it
`timescale 1ns/1ps
module ucb_cfg_port
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] byte_in,
  input wire logic byte_vld,
  output logic rdy,
  output logic [7:0] cfg_data,
  output logic cfg_strobe
);

  typedef enum logic [2:0] {
    CP_IDLE = 3'b001,
    CP_SETUP = 3'b010,
    CP_HIGH = 3'b100
  } ucb_cp_e;

  ucb_cp_e state_q;
  logic [7:0] cnt_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Setup cycle first, so the target never samples a changing byte
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q <= CP_IDLE;
      cfg_data <= ucb_pkg::CFG_BYTE_RST;
      cfg_strobe <= 1'b0;
      cnt_q <= 8'h00;
    end
    else
    begin
      case (state_q)
        CP_IDLE:
        begin
          if (byte_vld)
          begin
            cfg_data <= byte_in;
            state_q <= CP_SETUP;
          end
        end
        CP_SETUP:
        begin
          cfg_strobe <= 1'b1;
          cnt_q <= 8'(ucb_pkg::STROBE_HIGH_CYC);
          state_q <= CP_HIGH;
        end
        CP_HIGH:
        begin
          if (cnt_q <= 8'h01)
          begin
            cfg_strobe <= 1'b0;
            state_q <= CP_IDLE;
          end
          else
          begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default:
        begin
          state_q <= CP_IDLE;
        end
      endcase
    end
  end

  // Ready only when idle: one strobe for each accepted byte
  assign rdy = (state_q == CP_IDLE);

endmodule : ucb_cfg_port

// ===== hdl/ucb_lamp.sv
// Purpose: stretches activity pulses into a visible lamp flicker
// Assumes: pulses are one cycle wide
// Notes: retrigger restarts the hold, so steady traffic keeps the lamp lit
`timescale 1ns/1ps
module ucb_lamp
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic act,
  output logic lamp
);

  logic [19:0] hold_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Hold counter and lamp register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      hold_q <= 20'h00000;
      lamp <= 1'b0;
    end
    else if (act)
    begin
      hold_q <= 20'(ucb_pkg::LAMP_HOLD_CYC);
      lamp <= 1'b1;
    end
    else if (hold_q != 20'h00000)
    begin
      hold_q <= hold_q - 20'h00001;
    end
    else
    begin
      lamp <= 1'b0;
    end
  end

endmodule : ucb_lamp

// ===== hdl/ucb_router.sv
// Purpose: routes USB requests and bulk bytes to FPGA configuration or the user-side bus
// Assumes: bytes and requests come from the microcontroller's external memory bus pins
// Notes: control requests are taken one at a time; bulk traffic bypasses the core
`timescale 1ns/1ps
module ucb_router
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire ucb_pkg::ucb_req_s REQ,
  output logic REQ_BUSY,
  output logic REQ_DONE,
  output logic [7:0] REQ_RESULT,
  input wire logic [7:0] WR_BYTE,
  input wire logic WR_VALID,
  output logic WR_READY,
  input wire logic RD_REQ,
  output logic [7:0] RD_BYTE,
  output logic RD_VALID,
  output logic [7:0] CFG_DATA,
  output logic CFG_STROBE,
  output logic [ucb_pkg::NUM_FPGA-1:0] CFG_SELECT_N,
  output logic [ucb_pkg::NUM_FPGA-1:0] CFG_CLEAR_N,
  input wire logic [7:0] CFG_RD_DATA,
  input wire logic [ucb_pkg::NUM_FPGA-1:0] CFG_DONE,
  output logic [ucb_pkg::NUM_FPGA-1:0] DONE_LAMP,
  output ucb_pkg::ucb_ubus_s UBUS,
  input wire logic UBUS_VALID,
  input wire logic [31:0] UBUS_RDATA,
  input wire logic UBUS_DISABLE,
  input wire logic FW_UPDATE_SW,
  output logic FW_UPDATE_MODE,
  output logic ACT_LAMP
);

  typedef enum logic [3:0] {
    UB_IDLE = 4'b0001,
    UB_WAIT = 4'b0010,
    UB_SEND = 4'b0100,
    UB_LAST = 4'b1000
  } ucb_ub_e;

  logic cfg_mode_q;
  logic [ucb_pkg::NUM_FPGA-1:0] sel_q;
  logic [ucb_pkg::LEN_W-1:0] rd_len_q;
  logic [ucb_pkg::LEN_W-1:0] rd_left_q;
  logic [31:0] addr_q;
  logic [31:0] word_q;
  logic [7:0] code_q;
  logic [2:0] rec_idx_q;
  logic [1:0] byte_idx_q;
  logic [15:0] tmo_q;
  logic [31:0] rword_q;
  ucb_ub_e ub_q;
  logic cp_rdy;
  logic cp_vld;
  logic wr_take;
  logic fw_seen_q;
  logic act_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Control requests, one at a time: busy for the cycle after acceptance
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      cfg_mode_q <= 1'b0;
      sel_q <= '0;
      CFG_CLEAR_N <= '1;
      rd_len_q <= '0;
      REQ_BUSY <= 1'b0;
      REQ_DONE <= 1'b0;
      REQ_RESULT <= 8'h00;
    end
    else
    begin
      REQ_DONE <= 1'b0;
      CFG_CLEAR_N <= '1;
      if (REQ_BUSY)
      begin
        REQ_BUSY <= 1'b0;
        REQ_DONE <= 1'b1;
      end
      else if (REQ.valid)
      begin
        REQ_BUSY <= 1'b1;
        REQ_RESULT <= 8'h00;
        case (REQ.code)
          ucb_pkg::REQ_SELECT_TARGET:
          begin
            sel_q <= ucb_pkg::target_onehot(REQ.arg);
            CFG_CLEAR_N <= ~ucb_pkg::target_onehot(REQ.arg);
            cfg_mode_q <= 1'b1;
          end
          ucb_pkg::REQ_DESELECT_TARGET:
          begin
            REQ_RESULT <= {7'h00, |(CFG_DONE & sel_q)};
            sel_q <= '0;
            cfg_mode_q <= 1'b0;
          end
          ucb_pkg::REQ_READ_LENGTH:
            rd_len_q <= REQ.value;
          default:
            REQ_RESULT <= 8'h00;
        endcase
      end
    end
  end

  // Selects are registered; only the chosen FPGA sees the config port
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      CFG_SELECT_N <= '1;
      DONE_LAMP <= '0;
    end
    else
    begin
      CFG_SELECT_N <= ~sel_q;
      DONE_LAMP <= CFG_DONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write path steering: config port in config mode, records otherwise
  assign wr_take = WR_VALID && WR_READY;
  assign cp_vld = WR_VALID && cfg_mode_q && cp_rdy && !WR_READY;
  // Ready pulses for one cycle as the byte is consumed; a read start holds a record
  // byte back, since the engine closes a record only while it is idle
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
      WR_READY <= 1'b0;
    else if (cfg_mode_q)
      WR_READY <= cp_vld;
    else
      WR_READY <= WR_VALID && !WR_READY && ub_q == UB_IDLE && !RD_REQ;
  end

  ucb_cfg_port u_cfg_port
  (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .byte_in(WR_BYTE),
    .byte_vld(cp_vld),
    .rdy(cp_rdy),
    .cfg_data(CFG_DATA),
    .cfg_strobe(CFG_STROBE)
  );

  // Record assembly: code byte, then four data bytes least significant first
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      rec_idx_q <= 3'h0;
      code_q <= 8'h00;
      word_q <= 32'h00000000;
    end
    else if (cfg_mode_q)
      rec_idx_q <= 3'h0; // Partial records are dropped on mode change
    else if (wr_take)
    begin
      if (rec_idx_q == 3'h0)
        code_q <= WR_BYTE;
      else
        word_q <= {WR_BYTE, word_q[31:8]};
      rec_idx_q <= (rec_idx_q == ucb_pkg::REC_LEN - 3'h1) ? 3'h0 : rec_idx_q + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // User-side bus engine: writes, reads with timeout and disable answers
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      ub_q <= UB_IDLE;
      UBUS <= '0;
      addr_q <= ucb_pkg::ADDR_RST;
      tmo_q <= 16'h0000;
      rword_q <= 32'h00000000;
      rd_left_q <= '0;
      byte_idx_q <= 2'h0;
      RD_VALID <= 1'b0;
      RD_BYTE <= 8'h00;
    end
    else
    begin
      UBUS.wr <= 1'b0;
      UBUS.rd <= 1'b0;
      RD_VALID <= 1'b0;
      case (ub_q)
        UB_IDLE:
        begin
          if (wr_take && rec_idx_q == ucb_pkg::REC_LEN - 3'h1)
          begin
            if (code_q == ucb_pkg::REC_LOAD_ADDR)
              addr_q <= {WR_BYTE, word_q[31:8]};
            else if (code_q == ucb_pkg::REC_WRITE_DATA)
            begin
              if (!UBUS_DISABLE)
              begin
                UBUS.wr <= 1'b1;
                UBUS.addr <= addr_q;
                UBUS.data <= {WR_BYTE, word_q[31:8]};
              end
              addr_q <= addr_q + 32'h00000001;
            end
          end
          else if (RD_REQ && cfg_mode_q)
          begin
            RD_BYTE <= CFG_RD_DATA;
            RD_VALID <= 1'b1;
          end
          else if (RD_REQ && !cfg_mode_q)
          begin
            rd_left_q <= rd_len_q;
            tmo_q <= 16'(ucb_pkg::BUS_TIMEOUT_CYC);
            if (UBUS_DISABLE)
            begin
              rword_q <= ucb_pkg::ERR_DISABLED;
              ub_q <= UB_SEND;
            end
            else
            begin
              UBUS.rd <= 1'b1;
              UBUS.addr <= addr_q;
              ub_q <= UB_WAIT;
            end
            byte_idx_q <= 2'h0;
          end
        end
        UB_WAIT:
        begin
          if (UBUS_VALID)
          begin
            rword_q <= UBUS_RDATA;
            ub_q <= UB_SEND;
          end
          else if (tmo_q == 16'h0000)
          begin
            rword_q <= ucb_pkg::ERR_TIMEOUT;
            ub_q <= UB_SEND;
          end
          else
            tmo_q <= tmo_q - 16'h0001;
        end
        UB_SEND:
        begin
          RD_BYTE <= rword_q[7:0];
          RD_VALID <= 1'b1;
          rword_q <= {8'h00, rword_q[31:8]};
          rd_left_q <= rd_left_q - 16'h0001;
          byte_idx_q <= byte_idx_q + 2'h1;
          if (byte_idx_q == ucb_pkg::WORD_LAST)
            ub_q <= UB_LAST;
        end
        UB_LAST:
        begin
          addr_q <= addr_q + 32'h00000001;
          if (rd_left_q == '0)
            ub_q <= UB_IDLE;
          else if (UBUS_DISABLE)
          begin
            rword_q <= ucb_pkg::ERR_DISABLED;
            ub_q <= UB_SEND;
          end
          else
          begin
            UBUS.rd <= 1'b1;
            UBUS.addr <= addr_q + 32'h00000001;
            tmo_q <= 16'(ucb_pkg::BUS_TIMEOUT_CYC);
            ub_q <= UB_WAIT;
          end
        end
        default:
          ub_q <= UB_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Firmware-update switch is caught once, on the first cycle after reset release
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      fw_seen_q <= 1'b0;
      FW_UPDATE_MODE <= 1'b0;
    end
    else if (!fw_seen_q)
    begin
      fw_seen_q <= 1'b1;
      FW_UPDATE_MODE <= FW_UPDATE_SW;
    end
  end

  // Any request or byte counts as USB traffic
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
      act_q <= 1'b0;
    else
      act_q <= REQ.valid || wr_take || RD_REQ;
  end
  ucb_lamp u_lamp
  (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .act(act_q),
    .lamp(ACT_LAMP)
  );
endmodule : ucb_router

// ===== tb/ucb_router_props.sv
// Purpose: concurrent checks on the router pins
// Assumes: one clock, synchronous active-low reset
// Notes: attached by bind below the module
`timescale 1ns/1ps
module ucb_router_props
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire ucb_pkg::ucb_req_s REQ,
  input wire logic REQ_BUSY,
  input wire logic REQ_DONE,
  input wire logic [7:0] WR_BYTE,
  input wire logic WR_READY,
  input wire logic [7:0] CFG_DATA,
  input wire logic CFG_STROBE,
  input wire logic [ucb_pkg::NUM_FPGA-1:0] CFG_SELECT_N,
  input wire logic [ucb_pkg::NUM_FPGA-1:0] CFG_CLEAR_N,
  input wire logic [ucb_pkg::NUM_FPGA-1:0] CFG_DONE,
  input wire logic [ucb_pkg::NUM_FPGA-1:0] DONE_LAMP,
  input wire ucb_pkg::ucb_ubus_s UBUS,
  input wire logic UBUS_DISABLE,
  input wire logic ACT_LAMP
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  logic take;
  logic cfg;
  // A request is taken only while idle; config mode means some target selected
  assign take = REQ.valid && !REQ_BUSY;
  assign cfg = CFG_SELECT_N != '1;
  //////////////////////////////////////////////////////////////////////////
  a_clear_on_select: assert property (take && REQ.code == 8'hB7 &&
    REQ.arg inside {[8'h01:8'h04]} |=> CFG_CLEAR_N == ~(4'h1 << ($past(REQ.arg) - 8'h01)))
    else $error("clear pulse missing on select");
  a_req_answer: assert property (take |=> REQ_BUSY ##1 REQ_DONE)
    else $error("request not answered in order");
  a_strobe_single: assert property (CFG_STROBE |=> !CFG_STROBE)
    else $error("strobe wider than one cycle");
  a_data_stable: assert property (CFG_STROBE |-> $stable(CFG_DATA))
    else $error("config byte moved at strobe");
  a_byte_strobe: assert property (WR_READY && cfg |=> CFG_STROBE)
    else $error("no strobe for config byte");
  a_byte_no_swap: assert property (WR_READY && cfg |-> CFG_DATA == $past(WR_BYTE))
    else $error("config byte bit order wrong");
  a_select_onehot: assert property ($onehot0(~CFG_SELECT_N))
    else $error("more than one target selected");
  a_deselect_drops: assert property (take && REQ.code == 8'hBD |->
    ##[1:2] CFG_SELECT_N == '1)
    else $error("deselect kept a target");
  a_lamp_follows: assert property ($past(RST_N) |-> DONE_LAMP == $past(CFG_DONE))
    else $error("completion lamp wrong");
  a_disabled_quiet: assert property (UBUS_DISABLE && $past(UBUS_DISABLE) |->
    !UBUS.wr && !UBUS.rd)
    else $error("user bus used while disabled");
  a_cfg_no_ubus: assert property (cfg |-> !UBUS.wr)
    else $error("user bus write in config mode");
  a_act_flicker: assert property (WR_READY |-> ##[0:2] ACT_LAMP)
    else $error("activity lamp dark on traffic");
  c_select: cover property (take && REQ.code == 8'hB7);
  c_strobe: cover property (CFG_STROBE);
  c_ubus_rd: cover property (UBUS.rd);
endmodule : ucb_router_props

bind ucb_router ucb_router_props ucb_router_props_i (.CLK_SYS, .RST_N, .REQ, .REQ_BUSY,
  .REQ_DONE, .WR_BYTE, .WR_READY, .CFG_DATA, .CFG_STROBE, .CFG_SELECT_N, .CFG_CLEAR_N,
  .CFG_DONE, .DONE_LAMP, .UBUS, .UBUS_DISABLE, .ACT_LAMP);

// ===== tb/ucb_ubus_tgt.sv
// Purpose: user-side bus target standing beyond the router
// Assumes: one read pulse per word
// Notes: data lines change every idle cycle so stale values never pass
`timescale 1ns/1ps
module ucb_ubus_tgt
#(
  parameter logic [31:0] KEY = 32'hC35A0F96
)
(
  input wire logic clk,
  input wire ucb_pkg::ucb_ubus_s bus,
  input wire logic mute,
  input wire logic [2:0] lag,
  output logic vld,
  output logic [31:0] rdata
);
  int cnt = -1;
  logic [31:0] word = 32'h0;
  initial vld = 1'b0;
  initial rdata = 32'h0;
  //////////////////////////////////////////////////////////////////////////
  // Answer lag+1 cycles after the read pulse is sampled; mute models a target that never answers
  always @(posedge clk)
  begin
    vld <= 1'b0;
    rdata <= ~rdata;
    if (bus.rd && !mute)
    begin
      cnt <= lag;
      word <= bus.addr ^ KEY;
    end
    else if (cnt == 0)
    begin
      vld <= 1'b1;
      rdata <= word;
      cnt <= -1;
    end
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
endmodule : ucb_ubus_tgt

// ===== tb/tb_top.sv
// Purpose: self-checking bench for the USB configuration bus router
// Assumes: 10 MHz clock, inputs driven at the falling edge
// Notes: expected results queue per output stream and are popped as they appear
`timescale 1ns/1ps
module tb_top;
  localparam logic [31:0] KEY = 32'hC35A0F96;
  logic CLK_SYS, RST_N, REQ_BUSY, REQ_DONE, WR_VALID, WR_READY, RD_REQ, RD_VALID;
  logic CFG_STROBE, UBUS_VALID, UBUS_DISABLE, FW_UPDATE_SW, FW_UPDATE_MODE, ACT_LAMP, mute;
  logic [7:0] REQ_RESULT, WR_BYTE, RD_BYTE, CFG_DATA, CFG_RD_DATA, b;
  logic [3:0] CFG_SELECT_N, CFG_CLEAR_N, CFG_DONE, DONE_LAMP, clr_obs, exp_oh;
  logic [31:0] UBUS_RDATA, addr, d;
  logic [2:0] lag;
  ucb_pkg::ucb_req_s REQ;
  ucb_pkg::ucb_ubus_s UBUS;
  logic [63:0] q_cfg[$], q_wr[$], q_rd[$], q_res[$];
  int fail_count = 0;
  int n_checks = 0;
  int seed;
  int cyc = 0;
  ucb_router ucb_router_i (.CLK_SYS, .RST_N, .REQ, .REQ_BUSY, .REQ_DONE, .REQ_RESULT,
    .WR_BYTE, .WR_VALID, .WR_READY, .RD_REQ, .RD_BYTE, .RD_VALID, .CFG_DATA, .CFG_STROBE,
    .CFG_SELECT_N, .CFG_CLEAR_N, .CFG_RD_DATA, .CFG_DONE, .DONE_LAMP, .UBUS, .UBUS_VALID,
    .UBUS_RDATA, .UBUS_DISABLE, .FW_UPDATE_SW, .FW_UPDATE_MODE, .ACT_LAMP);
  ucb_ubus_tgt #(.KEY(KEY)) ucb_ubus_tgt_i (.clk(CLK_SYS), .bus(UBUS), .mute, .lag,
    .vld(UBUS_VALID), .rdata(UBUS_RDATA));
  //////////////////////////////////////////////////////////////////////////
  // Clock and a watchdog that cuts a hang short
  initial
  begin
    CLK_SYS = 1'b0;
    forever #50 CLK_SYS = ~CLK_SYS;
  end
  always @(posedge CLK_SYS)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // An empty queue yields unknown, so a surplus result always mismatches
  function automatic logic [63:0] take(ref logic [63:0] q[$]);
    return q.size() > 0 ? q.pop_front() : 'x;
  endfunction : take
  //////////////////////////////////////////////////////////////////////////
  // Output watcher at the falling edge, where registered outputs have settled
  always @(negedge CLK_SYS)
  if (RST_N)
  begin
    if (CFG_CLEAR_N !== 4'hF) clr_obs = CFG_CLEAR_N;
    if (CFG_STROBE) chk(64'(CFG_DATA), take(q_cfg));
    if (UBUS.wr) chk({UBUS.addr, UBUS.data}, take(q_wr));
    if (RD_VALID) chk(64'(RD_BYTE), take(q_rd));
    if (REQ_DONE) chk(64'(REQ_RESULT), take(q_res));
  end
  task automatic drain();
    int n;
    n = 0;
    while (q_cfg.size() + q_wr.size() + q_rd.size() + q_res.size() != 0 && n < 3000)
    begin
      @(negedge CLK_SYS);
      n++;
    end
    if (n >= 3000) chk(64'h0, 64'h1);
    repeat (3) @(negedge CLK_SYS);
  endtask : drain
  // Request held over exactly one edge, taken there since the block is idle
  task automatic req(input logic [7:0] c, input logic [7:0] a, input logic [15:0] v,
    input logic [7:0] r);
    @(negedge CLK_SYS);
    q_res.push_back(64'(r));
    REQ = '{valid: 1'b1, code: c, arg: a, value: v};
    @(negedge CLK_SYS);
    REQ.valid = 1'b0;
    drain();
  endtask : req
  // Byte held until the edge at which ready is high, then released
  task automatic wb(input logic [7:0] v);
    int n;
    n = 0;
    @(negedge CLK_SYS);
    WR_BYTE = v;
    WR_VALID = 1'b1;
    do
    begin
      @(negedge CLK_SYS);
      n++;
    end
    while (WR_READY !== 1'b1 && n < 50);
    @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    WR_VALID = 1'b0;
    if (n >= 50) chk(64'h0, 64'h1);
  endtask : wb
  task automatic rec(input logic [7:0] c, input logic [31:0] v);
    wb(c);
    for (int k = 0; k < 4; k++) wb(v[8*k+:8]);
  endtask : rec
  // Mode 0 target data, 1 timeout word, 2 disabled word, 3 config readback
  task automatic rd(input int n, input logic [31:0] a, input int mode);
    logic [31:0] w;
    req(8'hBB, 8'h00, 16'(n), 8'h00);
    lag = 3'($random(seed));
    if (mode == 3) q_rd.push_back(64'(CFG_RD_DATA));
    else for (int i = 0; i < n / 4; i++)
    begin
      w = mode == 0 ? (a + i) ^ KEY : mode == 1 ? ucb_pkg::ERR_TIMEOUT : ucb_pkg::ERR_DISABLED;
      for (int k = 0; k < 4; k++) q_rd.push_back(64'(w[8*k+:8]));
    end
    @(negedge CLK_SYS);
    RD_REQ = 1'b1;
    @(negedge CLK_SYS);
    RD_REQ = 1'b0;
    drain();
  endtask : rd
  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    seed = 32'h8FFB;
    RST_N = 1'b0;
    REQ = '0;
    {WR_VALID, RD_REQ, UBUS_DISABLE, mute, WR_BYTE, CFG_DONE, lag} = '0;
    FW_UPDATE_SW = 1'b1;
    CFG_RD_DATA = 8'h00;
    repeat (6) @(negedge CLK_SYS);
    RST_N = 1'b1;
    repeat (2) @(negedge CLK_SYS);
    chk(64'({CFG_SELECT_N, CFG_CLEAR_N}), 64'hFF);
    chk(64'(FW_UPDATE_MODE), 64'h1);
    FW_UPDATE_SW = 1'b0;
    for (int t = 1; t <= 5; t++)
    begin
      clr_obs = 4'hF;
      req(8'hB7, 8'(t), 16'h0000, 8'h00);
      exp_oh = t < 5 ? ~(4'h1 << (t - 1)) : 4'hF;
      chk(64'(clr_obs), 64'(exp_oh));
      chk(64'(CFG_SELECT_N), 64'(exp_oh));
    end
    clr_obs = 4'hF;
    req(8'h5A, 8'h03, 16'h0000, 8'h00);
    chk(64'({clr_obs, CFG_SELECT_N}), 64'hFF);
    $display("test select done");
    req(8'hB7, 8'h02, 16'h0000, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      b = i == 0 ? 8'h01 : 8'($random(seed));
      q_cfg.push_back(64'(b));
      wb(b);
    end
    drain();
    CFG_RD_DATA = 8'($random(seed));
    rd(1, 32'h0, 3);
    CFG_DONE = 4'b0010;
    repeat (2) @(negedge CLK_SYS);
    chk(64'(DONE_LAMP), 64'(CFG_DONE));
    req(8'hBD, 8'h00, 16'h0000, 8'h01);
    chk(64'(CFG_SELECT_N), 64'hF);
    $display("test config done");
    addr = $random(seed) & 32'hFFFFFFF0;
    rec(8'h00, addr);
    for (int j = 0; j < 2; j++)
    begin
      d = $random(seed);
      q_wr.push_back({addr + j, d});
      rec(8'h01, d);
    end
    rec(8'h02, $random(seed));
    drain();
    rd(8, addr + 2, 0);
    rd(4, addr + 4, 0);
    chk(64'(ACT_LAMP), 64'h1);
    $display("test user bus done");
    mute = 1'b1;
    rd(4, 32'h0, 1);
    mute = 1'b0;
    UBUS_DISABLE = 1'b1;
    rec(8'h01, $random(seed));
    rd(4, 32'h0, 2);
    chk(64'(FW_UPDATE_MODE), 64'h1);
    $display("test faults done");
    results();
  end
endmodule : tb_top
